// file: hdl/temp_sensor_serial_conversion.sv
/*
  Digital side of a micropower temperature sensor: conversion scheduler,
  result buffer and readable temperature register, and the 4-wire serial
  slave port. Assumes the analog converter presents its result on
  adc_sample_in, valid at the end of each conversion, and that the serial
  pins come from another clock domain and are synchronised here.
*/
`timescale 1ns/10ps

module temp_sensor_serial_conversion
  import temp_sensor_pkg::*;
#(
  parameter int unsigned INTERVAL_CYCLES = CONV_INTERVAL_CYCLES,
  parameter int unsigned CONVERT_CYCLES = CONV_TIME_CYCLES
) (
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic reset_in,
  // Serial pins
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic din_in,
  output logic dout_out,
  output logic dout_en_n_out,
  // Analog converter
  input wire logic [TEMP_W-1:0] adc_sample_in,
  output logic analog_power_out,
  // Status
  output logic shutdown_out,
  output logic [TEMP_W-1:0] temperature_out
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic frame_bit(input logic [TEMP_W-1:0] temp,
                                     input logic [BIT_CNT_W-1:0] idx);
    logic [FRAME_BITS-1:0] word;
    word = {LEAD_ZEROS, temp};
    frame_bit = word[LAST_BIT_IDX - idx];
  endfunction

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  serial_pins_s pins_meta_ff;
  serial_pins_s pins_sync_ff;
  logic sclk_prev_ff;
  logic cs_n_prev_ff;
  logic [BIT_CNT_W-1:0] rise_cnt_ff;
  logic [BIT_CNT_W-1:0] fall_cnt_ff;
  logic [FRAME_BITS-1:0] ctrl_shift_ff;
  logic [FRAME_BITS-1:0] control_ff;
  logic shutdown_ff;
  logic activity_ff;
  logic first_fall_ff;
  logic dout_ff;
  logic dout_en_n_ff;
  logic [TEMP_W-1:0] buffer_ff;
  logic buffer_new_ff;
  logic [TEMP_W-1:0] temperature_ff;
  conv_state_e conv_state_ff;
  conv_state_e nxt_conv_state;
  logic [TIMER_W-1:0] interval_cnt_ff;
  logic [TIMER_W-1:0] conv_cnt_ff;
  logic analog_power_ff;

  logic selected;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_start;
  logic frame_end;
  logic ctrl_load;
  logic [FRAME_BITS-1:0] nxt_control;
  logic leave_shutdown;
  logic interval_expired;
  logic start_after_io;
  logic conv_start;
  logic conv_done;
  logic copy_buffer;
  logic [TEMP_W-1:0] nxt_temperature;

  // ----------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------------
  // The serial clock is sampled, not used as a clock, so the master's clock
  // must stay well below half the system rate.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      pins_meta_ff <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
      pins_sync_ff <= '{cs_n: 1'b1, sclk: 1'b0, din: 1'b0};
      sclk_prev_ff <= 1'b0;
      cs_n_prev_ff <= 1'b1;
    end else begin
      pins_meta_ff <= '{cs_n: cs_n_in, sclk: sclk_in, din: din_in};
      pins_sync_ff <= pins_meta_ff;
      sclk_prev_ff <= pins_sync_ff.sclk;
      cs_n_prev_ff <= pins_sync_ff.cs_n;
    end
  end

  assign selected = !pins_sync_ff.cs_n;
  assign sclk_rise = selected && pins_sync_ff.sclk && !sclk_prev_ff;
  assign sclk_fall = selected && !pins_sync_ff.sclk && sclk_prev_ff;
  assign frame_start = cs_n_prev_ff && !pins_sync_ff.cs_n;
  assign frame_end = !cs_n_prev_ff && pins_sync_ff.cs_n;

  // ----------------------------------------------------------------------
  // Serial input and control register
  // ----------------------------------------------------------------------
  assign ctrl_load = sclk_rise && (rise_cnt_ff == LAST_BIT_IDX);
  assign nxt_control = {ctrl_shift_ff[FRAME_BITS-2:0], pins_sync_ff.din};
  assign leave_shutdown = ctrl_load && shutdown_ff && !nxt_control[PWR_DOWN_POS];

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      rise_cnt_ff <= '0;
      ctrl_shift_ff <= CTRL_RESET;
    end else if (frame_start) begin
      // A frame cut short leaves only a partial shift, which is discarded here.
      rise_cnt_ff <= '0;
      ctrl_shift_ff <= CTRL_RESET;
    end else if (sclk_rise) begin
      rise_cnt_ff <= rise_cnt_ff + 4'h1;
      ctrl_shift_ff <= nxt_control;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      control_ff <= CTRL_RESET;
      shutdown_ff <= 1'b0;
    end else if (ctrl_load) begin
      control_ff <= nxt_control;
      shutdown_ff <= nxt_control[PWR_DOWN_POS];
    end
  end

  // ----------------------------------------------------------------------
  // Transaction tracking
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      activity_ff <= 1'b0;
    end else if (frame_start) begin
      activity_ff <= 1'b0;
    end else if (sclk_rise || sclk_fall) begin
      activity_ff <= 1'b1;
    end
  end

  // Starts set so that a master that never deselects still gets one copy.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      first_fall_ff <= 1'b1;
    end else if (frame_start) begin
      first_fall_ff <= 1'b1;
    end else if (sclk_fall) begin
      first_fall_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Temperature register and serial output
  // ----------------------------------------------------------------------
  assign copy_buffer = sclk_fall && first_fall_ff && buffer_new_ff &&
                       (conv_state_ff == CONV_IDLE);
  assign nxt_temperature = copy_buffer ? buffer_ff : temperature_ff;

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      temperature_ff <= TEMP_RESET;
    end else begin
      temperature_ff <= nxt_temperature;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      fall_cnt_ff <= '0;
    end else if (frame_start) begin
      fall_cnt_ff <= '0;
    end else if (sclk_fall) begin
      fall_cnt_ff <= fall_cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      dout_ff <= 1'b0;
      dout_en_n_ff <= 1'b1;
    end else if (!selected) begin
      dout_ff <= 1'b0;
      dout_en_n_ff <= 1'b1;
    end else if (frame_start) begin
      dout_ff <= frame_bit(temperature_ff, 4'h0);
      dout_en_n_ff <= 1'b0;
    end else if (sclk_fall) begin
      dout_ff <= frame_bit(nxt_temperature, fall_cnt_ff + 4'h1);
      dout_en_n_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Conversion scheduler
  // ----------------------------------------------------------------------
  assign interval_expired = !shutdown_ff &&
                            (interval_cnt_ff == TIMER_W'(INTERVAL_CYCLES - 1));
  assign start_after_io = frame_end && activity_ff && !shutdown_ff;
  assign conv_start = (conv_state_ff == CONV_IDLE) &&
                      (interval_expired || start_after_io || leave_shutdown);
  assign conv_done = (conv_state_ff == CONV_RUN) &&
                     (conv_cnt_ff == TIMER_W'(CONVERT_CYCLES - 1));

  // Runs on the system clock, but is held clear in shutdown and restarted after each transfer with clock edges.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      interval_cnt_ff <= '0;
    end else if (shutdown_ff && !leave_shutdown) begin
      interval_cnt_ff <= '0;
    end else if (frame_end && activity_ff) begin
      interval_cnt_ff <= '0;
    end else if (leave_shutdown || interval_expired) begin
      interval_cnt_ff <= '0;
    end else begin
      interval_cnt_ff <= interval_cnt_ff + 24'h000001;
    end
  end

  always_comb begin
    nxt_conv_state = conv_state_ff;
    case (conv_state_ff)
      CONV_IDLE: begin
        if (conv_start) begin
          nxt_conv_state = CONV_RUN;
        end
      end
      CONV_RUN: begin
        // Only completion ends a conversion; serial traffic has no say here.
        if (conv_done) begin
          nxt_conv_state = CONV_IDLE;
        end
      end
      default: begin
        nxt_conv_state = CONV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      conv_state_ff <= CONV_IDLE;
      analog_power_ff <= 1'b0;
    end else begin
      conv_state_ff <= nxt_conv_state;
      analog_power_ff <= (nxt_conv_state == CONV_RUN);
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      conv_cnt_ff <= '0;
    end else if (conv_state_ff == CONV_RUN && !conv_done) begin
      conv_cnt_ff <= conv_cnt_ff + 24'h000001;
    end else begin
      conv_cnt_ff <= '0;
    end
  end

  // The completion setting the flag wins over a copy clearing it.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in) begin
      buffer_ff <= TEMP_RESET;
      buffer_new_ff <= 1'b0;
    end else if (conv_done) begin
      buffer_ff <= adc_sample_in;
      buffer_new_ff <= 1'b1;
    end else if (copy_buffer) begin
      buffer_new_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  assign dout_out = dout_ff;
  assign dout_en_n_out = dout_en_n_ff;
  assign analog_power_out = analog_power_ff;
  assign shutdown_out = shutdown_ff;
  assign temperature_out = temperature_ff;

endmodule

// file: shared/temp_sensor_pkg.sv
/*
  Constants, timing counts and carrier types for the serial temperature sensor
  readout block. Assumes a 10 MHz system clock that stands in for the internal
  conversion oscillator.
*/
package temp_sensor_pkg;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_FREQ_HZ = 10_000_000;
  localparam int unsigned CONV_INTERVAL_MS = 1500;
  localparam int unsigned CONV_TIME_US = 1200;
  localparam int unsigned CONV_INTERVAL_CYCLES = CONV_INTERVAL_MS * (CLK_FREQ_HZ / 1000);
  localparam int unsigned CONV_TIME_CYCLES = CONV_TIME_US * (CLK_FREQ_HZ / 1_000_000);
  localparam int unsigned TIMER_W = 24;

  // ----------------------------------------------------------------------
  // Frame and register layout
  // ----------------------------------------------------------------------
  localparam int unsigned TEMP_W = 14;
  localparam int unsigned FRAME_BITS = 16;
  localparam int unsigned BIT_CNT_W = 4;
  localparam int unsigned SIGN_BIT_POS = 13;
  localparam int unsigned PWR_DOWN_POS = 13;
  localparam logic [1:0] LEAD_ZEROS = 2'h0;
  localparam logic [3:0] LAST_BIT_IDX = 4'hF;
  localparam logic [FRAME_BITS-1:0] CTRL_RESET = 16'h0000;
  localparam logic [TEMP_W-1:0] TEMP_RESET = 14'h0000;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic din;
  } serial_pins_s;

  typedef enum logic [0:0] {
    CONV_IDLE = 1'b0,
    CONV_RUN  = 1'b1
  } conv_state_e;

endpackage

// file: verification/serial_master_model.sv
/*
  Serial master model: frames each transfer with select, clock idles high.
  Assumes the bench calls xfer and waits on the done event.
*/
`timescale 1ns/10ps
module serial_master_model
  import temp_sensor_pkg::*;
(
  // Pins
  output serial_pins_s pins_out,
  input wire logic dout_in,
  input wire logic dout_en_n_in,
  // Captured stream
  output logic [31:0] rx_out
);
  localparam int HALF = 400;
  event done;

  initial begin
    pins_out = '{cs_n: 1'b1, sclk: 1'b1, din: 1'b0};
    rx_out = 32'h0000_0000;
  end

  // Fewer than 16 clocks models an early deselect; a released output reads as the inverse of the last captured bit.
  task automatic xfer(input logic [15:0] w, input int n);
    #13;
    rx_out = 32'h0000_0000;
    pins_out.cs_n = 1'b0;
    #(2 * HALF);
    for (int i = 0; i < n; i++) begin
      rx_out = {rx_out[30:0], dout_en_n_in ? ~rx_out[0] : dout_in};
      pins_out.sclk = 1'b0;
      pins_out.din = w[15 - (i % 16)];
      #HALF;
      pins_out.sclk = 1'b1;
      #HALF;
    end
    #HALF;
    pins_out.cs_n = 1'b1;
    pins_out.din = ~pins_out.din;
    -> done;
  endtask
endmodule

// file: verification/tb_top.sv
/*
  Self-checking bench for the temperature sensor block.
  Assumes the package, design, master model and checker are compiled first.
*/
`timescale 1ns/10ps
module tb_top;
  import temp_sensor_pkg::*;
  localparam int unsigned INTERVAL_CYCLES = 2000;
  localparam int unsigned CONVERT_CYCLES = 100;
  logic clk_sys_in = 1'b0;
  logic reset_in = 1'b1;
  logic [TEMP_W-1:0] adc_sample_in = '0;
  serial_pins_s pins;
  logic dout_out, dout_en_n_out, analog_power_out, shutdown_out;
  logic [TEMP_W-1:0] temperature_out;
  logic [31:0] rx;
  logic [31:0] exp_q[$];
  int err_count = 0;
  int n_compared = 0;

  initial begin
    forever #50 clk_sys_in = ~clk_sys_in;
  end

  temp_sensor_serial_conversion #(.INTERVAL_CYCLES(INTERVAL_CYCLES),
    .CONVERT_CYCLES(CONVERT_CYCLES)) i_temp_sensor_serial_conversion (.clk_sys_in, .reset_in,
    .cs_n_in(pins.cs_n), .sclk_in(pins.sclk), .din_in(pins.din), .dout_out, .dout_en_n_out,
    .adc_sample_in, .analog_power_out, .shutdown_out, .temperature_out);
  serial_master_model u_master (.pins_out(pins), .dout_in(dout_out),
    .dout_en_n_in(dout_en_n_out), .rx_out(rx));

  task automatic check_word(input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: frame %h, wanted %h", $time, g, e);
    end
  endtask

  task automatic check_reg(input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("unexpected at %0t: value %h, wanted %h", $time, g, e);
    end
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clk_sys_in);
  endtask

  // A repeated frame carries the same word twice, so one shift covers any length up to 32.
  task automatic frame(input logic [15:0] w, input int n, input logic [TEMP_W-1:0] t);
    exp_q.push_back({2'b00, t, 2'b00, t} >> (32 - n));
    u_master.xfer(w, n);
    @(negedge clk_sys_in);
    check_reg({2'b00, t}, {2'b00, temperature_out});
  endtask

  task automatic test_done();
    if (err_count == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    forever begin
      @(u_master.done);
      check_word(exp_q.pop_front(), rx);
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys_in);
    err_count++;
    $display("unexpected at %0t: run did not finish", $time);
    test_done();
  end

  initial begin
    logic [TEMP_W-1:0] a, b, c, d;
    a = 14'($urandom(32'hD73BDFF6)) | 14'h2000;
    b = ~a;
    c = 14'($urandom());
    d = ~c;
    wait_clk(16);
    reset_in = 1'b0;
    wait_clk(4);
    check_reg(16'h0000, {2'b00, temperature_out});
    check_reg(16'h0000, {15'h0000, shutdown_out});
    adc_sample_in = a;
    frame(16'h0000, 32, 14'h0000);
    wait_clk(200);
    frame(16'h0000, 32, a);
    // The master reads a set sign bit as code minus 16384; sign extension must agree.
    check_word(32'(a) - 32'h0000_4000, 32'(signed'(temperature_out)));
    adc_sample_in = b;
    frame(16'h0000, 16, a);
    wait_clk(200);
    frame(16'h0000, 16, b);
    check_word(32'(b), 32'(signed'(temperature_out)));
    frame(16'h2000, 16, b);
    check_reg(16'h0001, {15'h0000, shutdown_out});
    adc_sample_in = c;
    wait_clk(INTERVAL_CYCLES + 500);
    check_reg(16'h0000, {15'h0000, analog_power_out});
    frame(16'h0000, 10, b);
    check_reg(16'h0001, {15'h0000, shutdown_out});
    frame(16'h0000, 16, b);
    check_reg(16'h0000, {15'h0000, shutdown_out});
    check_reg(16'h0001, {15'h0000, analog_power_out});
    wait_clk(200);
    frame(16'h0000, 16, c);
    wait_clk(150);
    adc_sample_in = d;
    wait_clk(INTERVAL_CYCLES + 300);
    frame(16'h0000, 16, d);
    test_done();
  end
endmodule

bind temp_sensor_serial_conversion temp_sensor_checker #(.INTERVAL_CYCLES(INTERVAL_CYCLES),
  .CONVERT_CYCLES(CONVERT_CYCLES)) i_checker (.clk_sys_in, .reset_in, .cs_n_in, .sclk_in,
  .dout_out, .dout_en_n_out, .analog_power_out, .shutdown_out, .temperature_out);

// file: verification/temp_sensor_properties.sv
/*
  Port checker for the temperature sensor block.
  Assumes a bind onto the design top; it sees only that module's ports.
*/
`timescale 1ns/10ps
module temp_sensor_checker
  import temp_sensor_pkg::*;
#(
  parameter int unsigned INTERVAL_CYCLES = 2000,
  parameter int unsigned CONVERT_CYCLES = 100
) (
  // Clock, reset and serial pins
  input wire logic clk_sys_in,
  input wire logic reset_in,
  input wire logic cs_n_in,
  input wire logic sclk_in,
  input wire logic dout_out,
  input wire logic dout_en_n_out,
  // Conversion and status
  input wire logic analog_power_out,
  input wire logic shutdown_out,
  input wire logic [TEMP_W-1:0] temperature_out
);
  int unsigned run_cnt_ff;
  int unsigned quiet_cnt_ff;
  logic edge_seen_ff;

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (reset_in);

  always_ff @(posedge clk_sys_in) begin
    run_cnt_ff <= (reset_in || !analog_power_out) ? 0 : run_cnt_ff + 1;
  end
  // Idle time is only counted where the interval timer alone may start a conversion.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || analog_power_out || !cs_n_in || shutdown_out) begin
      quiet_cnt_ff <= 0;
    end else begin
      quiet_cnt_ff <= quiet_cnt_ff + 1;
    end
  end
  // A frame without clock edges is not a transfer, so it must not demand a conversion.
  always_ff @(posedge clk_sys_in) begin
    if (reset_in || $fell(cs_n_in)) begin
      edge_seen_ff <= 1'b0;
    end else if (!cs_n_in && $changed(sclk_in)) begin
      edge_seen_ff <= 1'b1;
    end
  end

  a_release_deselect: assert property (
    cs_n_in[*6] |-> dout_en_n_out && !dout_out) else $error("output driven while deselected");
  a_lead_zero: assert property ($fell(cs_n_in) |-> ##6 (!dout_en_n_out && !dout_out))
    else $error("frame does not open with a driven zero");
  a_dout_on_fall: assert property (
    (sclk_in && !dout_en_n_out)[*3] |-> $stable(dout_out)) else $error("output moved in high phase");
  a_no_start_down: assert property ($rose(analog_power_out) |-> !shutdown_out)
    else $error("conversion started in shutdown");
  a_conv_length: assert property (
    $fell(analog_power_out) |-> run_cnt_ff inside {[CONVERT_CYCLES - 2:CONVERT_CYCLES + 2]})
    else $error("conversion length wrong");
  a_interval_bound: assert property (quiet_cnt_ff <= INTERVAL_CYCLES + 8)
    else $error("interval timer did not start a conversion");
  a_frame_end_conv: assert property (
    $rose(cs_n_in) && edge_seen_ff && !shutdown_out |-> ##[1:8] analog_power_out)
    else $error("no conversion after transfer");
  a_copy_in_frame: assert property (
    $changed(temperature_out) |-> !$past(cs_n_in, 2) && !$past(sclk_in, 2))
    else $error("temperature changed outside a falling clock");
  a_ctrl_in_frame: assert property ($changed(shutdown_out) |-> !$past(cs_n_in, 2))
    else $error("power-down changed outside a frame");
endmodule
